// File: pin_mux_pkg.sv
// Package with selection encodings, pin function codes and reset values for the pin mux
package pin_mux_pkg;
    // Codec clock source select
    localparam logic [1:0] CODEC_SRC_MCLK = 2'h0;
    localparam logic [1:0] CODEC_SRC_BCLK = 2'h1;
    localparam logic [1:0] CODEC_SRC_GPIO = 2'h2;
    localparam logic [1:0] CODEC_SRC_PLL = 2'h3;
    // PLL reference select
    localparam logic [1:0] PLL_REF_MCLK = 2'h0;
    localparam logic [1:0] PLL_REF_BCLK = 2'h1;
    localparam logic [1:0] PLL_REF_GPIO = 2'h2;
    localparam logic [1:0] PLL_REF_DIN = 2'h3;
    // Function codes for multifunction_pin_five (general-purpose pin)
    localparam logic [2:0] GPIO_FN_OFF = 3'h0;
    localparam logic [2:0] GPIO_FN_CLK_IN = 3'h1;
    localparam logic [2:0] GPIO_FN_GP_OUT = 3'h2;
    localparam logic [2:0] GPIO_FN_FIRST_IRQ = 3'h3;
    localparam logic [2:0] GPIO_FN_ADC_WCLK_IN = 3'h4;
    localparam logic [2:0] GPIO_FN_ADC_WCLK_OUT = 3'h5;
    localparam logic [2:0] GPIO_FN_GP_IN = 3'h6;
    // Function codes for multifunction_pin_three (SPI clock pin)
    localparam logic [1:0] PIN3_FN_OFF = 2'h0;
    localparam logic [1:0] PIN3_FN_ADC_WCLK_IN = 2'h1;
    localparam logic [1:0] PIN3_FN_GP_IN = 2'h2;
    // Function codes for multifunction_pin_four (SPI data-out pin)
    localparam logic [1:0] PIN4_FN_OFF = 2'h0;
    localparam logic [1:0] PIN4_FN_ADC_WCLK_OUT = 2'h1;
    localparam logic [1:0] PIN4_FN_FIRST_IRQ = 2'h2;
    localparam logic [1:0] PIN4_FN_GP_OUT = 2'h3;
    // Reset values
    localparam logic [1:0] CODEC_SRC_RESET = CODEC_SRC_MCLK;
    localparam logic [1:0] PLL_REF_RESET = PLL_REF_MCLK;
    localparam logic [2:0] GPIO_FN_RESET = GPIO_FN_OFF;
    localparam logic [1:0] PIN3_FN_RESET = PIN3_FN_OFF;
    localparam logic [1:0] PIN4_FN_RESET = PIN4_FN_OFF;
    localparam int ANALOG_BLOCKS = 8;
    localparam logic [7:0] ANALOG_PWR_RESET = 8'h00;
    // Clock switch: cycles the output clock stays gated on each side of a source change (before and after the select moves)
    localparam int GATE_TIME_NS = 64;
    localparam int CLK_PERIOD_NS = 8;
    localparam int GATE_CYCLES = (GATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] GATE_CNT_MAX = 4'(GATE_CYCLES);
endpackage

// File: clock_switch.sv
// Glitch-free clock source switch with gating during source changes
`timescale 1ns/1ps
module clock_switch
    import pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] sel_req,
    input wire logic [3:0] src_levels,
    output logic [1:0] sel_active_reg,
    output logic gated_reg,
    output logic clk_level_reg
);
    typedef enum logic [2:0] {
        SW_RUN = 3'b001,
        SW_GATE = 3'b010,
        SW_SWAP = 3'b100
    } sw_state_t;

    sw_state_t state_reg;
    logic [3:0] cnt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SW_RUN;
            cnt_reg <= 4'h0;
            sel_active_reg <= CODEC_SRC_RESET;
        end else begin
            case (state_reg)
                SW_RUN: begin
                    cnt_reg <= 4'h0;
                    if (sel_req != sel_active_reg) begin
                        state_reg <= SW_GATE;
                    end
                end
                SW_GATE: begin
                    // Old source held off before the select moves
                    if (cnt_reg == GATE_CNT_MAX - 4'h1) begin
                        sel_active_reg <= sel_req;
                        cnt_reg <= 4'h0;
                        state_reg <= SW_SWAP;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                SW_SWAP: begin
                    // New source settles while still gated
                    if (cnt_reg == GATE_CNT_MAX - 4'h1) begin
                        state_reg <= SW_RUN;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                default: begin
                    state_reg <= SW_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gated_reg <= 1'b1;
            clk_level_reg <= 1'b0;
        end else begin
            gated_reg <= (state_reg != SW_RUN) || (sel_req != sel_active_reg);
            clk_level_reg <= (state_reg == SW_RUN) && (sel_req == sel_active_reg)
                && src_levels[sel_active_reg];
        end
    end
endmodule

// File: codec_clock_and_pin_mux.sv
// Clock source selection and multifunction pin allocation for the codec
`timescale 1ns/1ps
module codec_clock_and_pin_mux
    import pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire logic [1:0] codec_clk_sel,
    input wire logic [1:0] pll_ref_sel,
    input wire logic bclk_dir_out,
    input wire logic wclk_dir_out,
    input wire logic [2:0] gpio_func_sel,
    input wire logic [1:0] pin3_func_sel,
    input wire logic [1:0] pin4_func_sel,
    input wire logic [7:0] analog_pwr_en,
    input wire logic spi_select_strap,
    input wire logic regulator_select_strap,
    // Pin inputs
    input wire logic mclk_in,
    input wire logic bclk_in,
    input wire logic wclk_in,
    input wire logic din_in,
    input wire logic multifunction_pin_three_in,
    input wire logic multifunction_pin_five_in,
    // Internal sources
    input wire logic pll_clk,
    input wire logic bclk_gen,
    input wire logic wclk_gen,
    input wire logic adc_wclk_gen,
    input wire logic dout_data,
    input wire logic gp_out_data,
    input wire logic first_irq_level,
    // Pin outputs
    output logic bclk_out,
    output logic bclk_oe,
    output logic wclk_out,
    output logic wclk_oe,
    output logic dout_out,
    output logic dout_oe,
    output logic multifunction_pin_four_out,
    output logic multifunction_pin_four_oe,
    output logic multifunction_pin_five_out,
    output logic multifunction_pin_five_oe,
    // Internal destinations
    output logic codec_clk,
    output logic codec_clk_gated,
    output logic pll_ref_clk,
    output logic iface_bclk,
    output logic iface_wclk,
    output logic iface_din,
    output logic adc_wclk_in,
    output logic gp_in_three,
    output logic gp_in_five,
    output logic [7:0] analog_pwr_up,
    output logic bus_is_spi,
    output logic regulator_sel,
    output logic config_conflict
);
    ////////////////////////////////////////////////////////////////////////////
    // Codec clock switch
    clock_switch u_switch (
        .clk(clk),
        .rst_n(rst_n),
        .sel_req(codec_clk_sel),
        .src_levels({pll_clk, multifunction_pin_five_in, bclk_in, mclk_in}),
        .sel_active_reg(),
        .gated_reg(codec_clk_gated),
        .clk_level_reg(codec_clk)
    );

    ////////////////////////////////////////////////////////////////////////////
    // PLL reference; pins shared with codec clock without exclusion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_ref_clk <= 1'b0;
        end else begin
            case (pll_ref_sel)
                PLL_REF_MCLK: pll_ref_clk <= mclk_in;
                PLL_REF_BCLK: pll_ref_clk <= bclk_in;
                PLL_REF_GPIO: pll_ref_clk <= multifunction_pin_five_in;
                PLL_REF_DIN: pll_ref_clk <= din_in;
                default: pll_ref_clk <= mclk_in;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Audio interface clocks, data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bclk_out <= 1'b0;
            bclk_oe <= 1'b0;
            wclk_out <= 1'b0;
            wclk_oe <= 1'b0;
            iface_bclk <= 1'b0;
            iface_wclk <= 1'b0;
            iface_din <= 1'b0;
            dout_out <= 1'b0;
            dout_oe <= 1'b1;
        end else begin
            bclk_oe <= bclk_dir_out;
            bclk_out <= bclk_dir_out & bclk_gen;
            wclk_oe <= wclk_dir_out;
            wclk_out <= wclk_dir_out & wclk_gen;
            // Bit clock still usable by interface while feeding PLL/codec
            iface_bclk <= bclk_dir_out ? bclk_gen : bclk_in;
            iface_wclk <= wclk_dir_out ? wclk_gen : wclk_in;
            iface_din <= din_in;
            dout_out <= dout_data;
            dout_oe <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Multifunction pins: each holds one function code, but pin five also feeds the codec clock and PLL reference whatever its code
    logic gpio_is_clock_src;
    assign gpio_is_clock_src = (codec_clk_sel == CODEC_SRC_GPIO) || (pll_ref_sel == PLL_REF_GPIO);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            multifunction_pin_five_out <= 1'b0;
            multifunction_pin_five_oe <= 1'b0;
            multifunction_pin_four_out <= 1'b0;
            multifunction_pin_four_oe <= 1'b0;
        end else begin
            case (gpio_func_sel)
                GPIO_FN_GP_OUT: begin
                    multifunction_pin_five_out <= gp_out_data;
                    multifunction_pin_five_oe <= 1'b1;
                end
                GPIO_FN_FIRST_IRQ: begin
                    multifunction_pin_five_out <= first_irq_level;
                    multifunction_pin_five_oe <= 1'b1;
                end
                GPIO_FN_ADC_WCLK_OUT: begin
                    multifunction_pin_five_out <= adc_wclk_gen;
                    multifunction_pin_five_oe <= 1'b1;
                end
                default: begin
                    multifunction_pin_five_out <= 1'b0;
                    multifunction_pin_five_oe <= 1'b0;
                end
            endcase
            case (pin4_func_sel)
                PIN4_FN_ADC_WCLK_OUT: begin
                    multifunction_pin_four_out <= adc_wclk_gen;
                    multifunction_pin_four_oe <= 1'b1;
                end
                PIN4_FN_FIRST_IRQ: begin
                    multifunction_pin_four_out <= first_irq_level;
                    multifunction_pin_four_oe <= 1'b1;
                end
                PIN4_FN_GP_OUT: begin
                    multifunction_pin_four_out <= gp_out_data;
                    multifunction_pin_four_oe <= 1'b1;
                end
                default: begin
                    multifunction_pin_four_out <= 1'b0;
                    multifunction_pin_four_oe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_wclk_in <= 1'b0;
            gp_in_three <= 1'b0;
            gp_in_five <= 1'b0;
        end else begin
            // SPI clock pin has priority when both offer the ADC word clock
            if (pin3_func_sel == PIN3_FN_ADC_WCLK_IN) begin
                adc_wclk_in <= multifunction_pin_three_in;
            end else if (gpio_func_sel == GPIO_FN_ADC_WCLK_IN) begin
                adc_wclk_in <= multifunction_pin_five_in;
            end else begin
                adc_wclk_in <= 1'b0;
            end
            gp_in_three <= (pin3_func_sel == PIN3_FN_GP_IN) & multifunction_pin_three_in;
            gp_in_five <= (gpio_func_sel == GPIO_FN_GP_IN) & multifunction_pin_five_in;
        end
    end

    // Flags a clock use of the GP pin while it holds any function code other than GPIO_FN_CLK_IN
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_conflict <= 1'b0;
        end else begin
            config_conflict <= gpio_is_clock_src && (gpio_func_sel != GPIO_FN_CLK_IN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog power enables and fixed-function straps
    genvar g;
    generate
        for (g = 0; g < ANALOG_BLOCKS; g++) begin : g_pwr
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    analog_pwr_up[g] <= ANALOG_PWR_RESET[g];
                end else begin
                    analog_pwr_up[g] <= analog_pwr_en[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_is_spi <= 1'b0;
            regulator_sel <= 1'b0;
        end else begin
            bus_is_spi <= spi_select_strap;
            regulator_sel <= regulator_select_strap;
        end
    end
endmodule

// File: pin_mux_monitor.sv
// Concurrent checks on the ports of the codec clock and pin mux
`timescale 1ns/1ps
module pin_mux_monitor
    import pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] codec_clk_sel,
    input wire logic [1:0] pll_ref_sel,
    input wire logic [2:0] gpio_func_sel,
    input wire logic [7:0] analog_pwr_en,
    input wire logic [7:0] analog_pwr_up,
    input wire logic spi_select_strap,
    input wire logic bus_is_spi,
    input wire logic bclk_dir_out,
    input wire logic bclk_gen,
    input wire logic bclk_oe,
    input wire logic bclk_out,
    input wire logic mclk_in,
    input wire logic bclk_in,
    input wire logic din_in,
    input wire logic multifunction_pin_five_in,
    input wire logic pll_clk,
    input wire logic gp_out_data,
    input wire logic multifunction_pin_five_oe,
    input wire logic multifunction_pin_five_out,
    input wire logic codec_clk,
    input wire logic codec_clk_gated,
    input wire logic pll_ref_clk
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire [3:0] ref_src = {din_in, multifunction_pin_five_in, bclk_in, mclk_in};
    wire [3:0] codec_src = {pll_clk, multifunction_pin_five_in, bclk_in, mclk_in};
    wire ref_now = ref_src[pll_ref_sel];
    wire codec_now = codec_src[codec_clk_sel];
    ////////////////////////////////////////////////////////////////////////////////
    a_pll_ref_route: assert property ($past(rst_n) |-> pll_ref_clk == $past(ref_now))
        else $error("pll reference off its pin");
    a_codec_route: assert property ($past(rst_n) && !codec_clk_gated |->
        codec_clk == $past(codec_now)) else $error("codec clock off its source");
    a_gated_low: assert property (codec_clk_gated |-> !codec_clk)
        else $error("codec clock runs while gated");
    a_gate_hold: assert property ($rose(codec_clk_gated) |-> codec_clk_gated [*8])
        else $error("gating too short");
    a_gate_on_change: assert property ($past(rst_n) && $changed(codec_clk_sel) &&
        !codec_clk_gated |=> codec_clk_gated) else $error("source change without gating");
    a_bclk_drive: assert property ($past(rst_n) |-> bclk_oe == $past(bclk_dir_out) &&
        bclk_out == ($past(bclk_gen) & $past(bclk_dir_out))) else $error("bit clock drive wrong");
    a_gp_out_only: assert property ($past(rst_n) &&
        $past(gpio_func_sel) == GPIO_FN_GP_OUT |->
        multifunction_pin_five_oe && multifunction_pin_five_out == $past(gp_out_data))
        else $error("pin five not a plain output");
    a_power_follow: assert property ($past(rst_n) |-> analog_pwr_up == $past(analog_pwr_en))
        else $error("power enable not followed");
    a_strap_follow: assert property ($past(rst_n) |-> bus_is_spi == $past(spi_select_strap))
        else $error("bus strap not followed");
    cover property ($rose(codec_clk_gated));
    cover property (pll_ref_sel == PLL_REF_DIN && pll_ref_clk);
    cover property ($past(gpio_func_sel) == GPIO_FN_GP_OUT && multifunction_pin_five_out);
endmodule

bind codec_clock_and_pin_mux pin_mux_monitor i_mon (.*);

// File: pin_source_model.sv
// Far-side pin and PLL clock sources feeding the mux
`timescale 1ns/1ps
module pin_source_model (
    input wire logic clk,
    input wire logic rst_n,
    output logic mclk_in,
    output logic bclk_in,
    output logic wclk_in,
    output logic din_in,
    output logic pll_clk,
    output logic multifunction_pin_three_in,
    output logic multifunction_pin_five_in
);
    logic [3:0] cnt_reg;
    // Distinct patterns repeating within four cycles (eight for wclk_in and pin three) so a wrong route shows within four samples
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) cnt_reg <= 4'h0;
        else cnt_reg <= cnt_reg + 4'h1;
    end
    assign mclk_in = cnt_reg[0];
    assign bclk_in = cnt_reg[1];
    assign din_in = cnt_reg[0] ^ cnt_reg[1];
    assign pll_clk = ~cnt_reg[0];
    assign wclk_in = cnt_reg[2];
    assign multifunction_pin_five_in = ~cnt_reg[1];
    assign multifunction_pin_three_in = cnt_reg[2] ^ cnt_reg[0];
endmodule

// File: tb_top.sv
// Self-checking bench for the codec clock and pin mux
`timescale 1ns/1ps
`define CMP(i, e, o) \
    samples_checked++; \
    if ((o) !== (e)) begin \
        fail_count++; \
        $display("mismatch %s expected %h seen %h", nm[i], e, o); \
    end
module tb_top
    import pin_mux_pkg::*;
;
    typedef struct {int s; logic [7:0] e;} note_t;
    logic clk, rst_n, bclk_dir_out, wclk_dir_out, spi_select_strap, regulator_select_strap;
    logic [1:0] codec_clk_sel, pll_ref_sel, pin3_func_sel, pin4_func_sel;
    logic [2:0] gpio_func_sel;
    logic [7:0] analog_pwr_en, analog_pwr_up;
    logic mclk_in, bclk_in, wclk_in, din_in, pll_clk;
    logic multifunction_pin_three_in, multifunction_pin_five_in;
    logic bclk_gen, wclk_gen, adc_wclk_gen, dout_data, gp_out_data, first_irq_level;
    logic bclk_out, bclk_oe, wclk_out, wclk_oe, dout_out, dout_oe;
    logic multifunction_pin_four_out, multifunction_pin_four_oe;
    logic multifunction_pin_five_out, multifunction_pin_five_oe;
    logic codec_clk, codec_clk_gated, pll_ref_clk, iface_bclk, iface_wclk, iface_din;
    logic adc_wclk_in, gp_in_three, gp_in_five, bus_is_spi, regulator_sel, config_conflict;
    int fail_count = 0;
    int samples_checked = 0;
    note_t exp_q[$];
    string nm[12] = '{"power", "straps", "pll_ref", "codec_clk", "pin_five", "pin_four",
        "adc_wclk", "bit_word_clk", "gated", "gp_in", "conflict", "data_pins"};
    wire [3:0] ref_src = {din_in, multifunction_pin_five_in, bclk_in, mclk_in};
    wire [3:0] codec_src = {pll_clk, multifunction_pin_five_in, bclk_in, mclk_in};

    codec_clock_and_pin_mux i_dut (.*);
    pin_source_model i_src (.*);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] model(int s);
        logic [2:0] f;
        logic [7:0] o5;
        logic [3:0] o4;
        f = gpio_func_sel;
        o5 = {2'h0, adc_wclk_gen, 1'b0, first_irq_level, gp_out_data, 2'h0};
        o4 = {gp_out_data, first_irq_level, adc_wclk_gen, 1'b0};
        case (s)
            0: return analog_pwr_en;
            1: return {6'h00, spi_select_strap, regulator_select_strap};
            2: return {7'h00, ref_src[pll_ref_sel]};
            3: return {7'h00, codec_src[codec_clk_sel]};
            4: return {6'h00, 1'(8'h2C >> f), o5[f]};
            5: return {6'h00, pin4_func_sel != 2'h0, o4[pin4_func_sel]};
            6: return {7'h00, pin3_func_sel == 2'h1 ? multifunction_pin_three_in :
                f == 3'h4 & multifunction_pin_five_in};
            7: return {2'h0, bclk_dir_out, bclk_gen & bclk_dir_out, wclk_dir_out,
                wclk_gen & wclk_dir_out, bclk_dir_out ? bclk_gen : bclk_in,
                wclk_dir_out ? wclk_gen : wclk_in};
            9: return {6'h00, pin3_func_sel == 2'h2 & multifunction_pin_three_in,
                f == 3'h6 & multifunction_pin_five_in};
            10: return {7'h00, (codec_clk_sel == 2'h2 || pll_ref_sel == 2'h2) && f != 3'h1};
            11: return {5'h00, 1'b1, dout_data, din_in};
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] obs(int s);
        case (s)
            0: return analog_pwr_up;
            1: return {6'h00, bus_is_spi, regulator_sel};
            2: return {7'h00, pll_ref_clk};
            3: return {7'h00, codec_clk};
            4: return {6'h00, multifunction_pin_five_oe,
                multifunction_pin_five_oe & multifunction_pin_five_out};
            5: return {6'h00, multifunction_pin_four_oe,
                multifunction_pin_four_oe & multifunction_pin_four_out};
            6: return {7'h00, adc_wclk_in};
            7: return {2'h0, bclk_oe, bclk_out, wclk_oe, wclk_out, iface_bclk, iface_wclk};
            8: return {7'h00, codec_clk_gated};
            9: return {6'h00, gp_in_three, gp_in_five};
            10: return {7'h00, config_conflict};
            default: return {5'h00, dout_oe, dout_out, iface_din};
        endcase
    endfunction
    task automatic note(int s, logic [7:0] e);
        exp_q.push_back('{s, e});
    endtask
    task automatic pred(int s);
        note(s, model(s));
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic nedge;
        @(negedge clk);
        {bclk_gen, wclk_gen, adc_wclk_gen, dout_data, gp_out_data, first_irq_level} = 6'($urandom);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wait_run;
        int w;
        for (w = 0; w < 40 && codec_clk_gated !== 1'b0; w++) tick;
        if (w == 40) begin
            fail_count++;
            wrap_up;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        note_t n;
        forever begin
            @(posedge clk);
            #2;
            while (exp_q.size() > 0) begin
                n = exp_q.pop_front();
                `CMP(n.s, n.e, obs(n.s))
            end
        end
    end
    initial begin
        int i;
        {rst_n, codec_clk_sel, pll_ref_sel, bclk_dir_out, wclk_dir_out, gpio_func_sel} = '0;
        {pin3_func_sel, pin4_func_sel, analog_pwr_en} = '0;
        {spi_select_strap, regulator_select_strap} = 2'h0;
        {bclk_gen, wclk_gen, adc_wclk_gen, dout_data, gp_out_data, first_irq_level} = 6'h00;
        void'($urandom(92506));
        repeat (10) @(posedge clk);
        nedge;
        rst_n = 1'b1;
        tick;
        pred(0);
        pred(7);
        pred(11);
        wait_run;
        for (i = 1; i < 5; i++) begin
            nedge;
            codec_clk_sel = 2'(i);
            pll_ref_sel = 2'(i);
            gpio_func_sel = GPIO_FN_CLK_IN;
            tick;
            tick;
            note(8, 8'h01);
            wait_run;
            repeat (4) begin
                nedge;
                tick;
                pred(3);
                pred(2);
                pred(7);
                pred(10);
            end
        end
        repeat (16) begin
            nedge;
            {bclk_dir_out, wclk_dir_out} = 2'($urandom);
            tick;
            pred(7);
            pred(11);
        end
        for (i = 0; i < 28; i++) begin
            nedge;
            pll_ref_sel = PLL_REF_GPIO;
            gpio_func_sel = 3'(i % 7);
            pin3_func_sel = 2'(i % 3);
            pin4_func_sel = 2'(i / 7);
            tick;
            pred(4);
            pred(5);
            pred(6);
            pred(9);
            pred(10);
        end
        repeat (8) begin
            nedge;
            analog_pwr_en = 8'($urandom);
            {spi_select_strap, regulator_select_strap} = 2'($urandom);
            tick;
            pred(0);
            pred(1);
        end
        nedge;
        rst_n = 1'b0;
        tick;
        note(0, 8'h00);
        note(8, 8'h01);
        note(11, 8'h04);
        tick;
        tick;
        wrap_up;
    end
endmodule
